// [rtl/crs_pkg.sv]
package crs_pkg;
   localparam int NUM_BANKS = 2;
   localparam int BANK_REGS = 7;
   localparam logic [2:0] BR_DATA0 = 3'h0;
   localparam logic [2:0] BR_DATA1 = 3'h1;
   localparam logic [2:0] BR_DATA2 = 3'h2;
   localparam logic [2:0] BR_DATA3 = 3'h3;
   localparam logic [2:0] BR_ADDR0 = 3'h4;
   localparam logic [2:0] BR_ADDR1 = 3'h5;
   localparam logic [2:0] BR_FBASE = 3'h6;
   localparam logic [5:0] ADDR_SBASE     = 6'h07;
   localparam logic [5:0] ADDR_USP       = 6'h08;
   localparam logic [5:0] ADDR_ISP       = 6'h09;
   localparam logic [5:0] ADDR_INTERRUPT_TABLE_BASE      = 6'h0a;
   localparam logic [5:0] ADDR_PC        = 6'h0b;
   localparam logic [5:0] ADDR_FLAGS     = 6'h0c;
   localparam logic [5:0] ADDR_DATA0_LO  = 6'h0d;
   localparam logic [5:0] ADDR_DATA0_HI  = 6'h0e;
   localparam logic [5:0] ADDR_DATA1_LO  = 6'h0f;
   localparam logic [5:0] ADDR_DATA1_HI  = 6'h10;
   localparam logic [5:0] ADDR_ACTIVE_SP = 6'h11;
   localparam logic [5:0] ADDR_PAIR_LOW  = 6'h12;
   localparam logic [5:0] ADDR_PAIR_HIGH = 6'h13;
   localparam logic [5:0] ADDR_ADDR_PAIR = 6'h14;
   localparam int FLG_CARRY  = 0;
   localparam int FLG_DEBUG  = 1;
   localparam int FLG_ZERO   = 2;
   localparam int FLG_SIGN   = 3;
   localparam int FLG_BANK   = 4;
   localparam int FLG_OVFL   = 5;
   localparam int FLG_IEN    = 6;
   localparam int FLG_STACK  = 7;
   localparam int FLG_IPL_LO = 12;
   localparam int FLG_IPL_HI = 14;
   localparam logic [15:0] FLG_IMPL_MASK = 16'h70ff;
   localparam logic [15:0] FLAGS_RESET   = 16'h0000;
   localparam logic [15:0] WORD_RESET    = 16'h0000;
   localparam logic [19:0] PC_RESET      = 20'h00000;
   localparam logic [19:0] INTERRUPT_TABLE_BASE_RESET    = 20'h00000;
   localparam logic [5:0]  SWI_STACK_LIMIT = 6'h20;
endpackage

// [rtl/crs_word_reg.sv]
`timescale 1ns/1ps
// A 16-bit register whose two byte lanes load independently.
module crs_word_reg
   import crs_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        wrLo,
   input  wire logic        wrHi,
   input  wire logic [15:0] dIn,
   output logic      [15:0] q
);
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         q <= WORD_RESET;
      end
      else
      begin
         if (wrLo)
         begin
            q[7:0] <= dIn[7:0];
         end
         if (wrHi)
         begin
            q[15:8] <= dIn[15:8];
         end
      end
   end
endmodule

// [rtl/crs_irq_gate.sv]
`timescale 1ns/1ps
// Decides whether a pending request may be taken now.
module crs_irq_gate
   import crs_pkg::*;
(
   input  wire logic       irqRequest,
   input  wire logic       irqNonMaskable,
   input  wire logic [2:0] irqPriority,
   input  wire logic [2:0] priorityLevel,
   input  wire logic       intEnable,
   output logic            irqAccept
);
   always_comb
   begin
      irqAccept = 1'b0;
      if (irqRequest)
      begin
         if (irqNonMaskable)
         begin
            irqAccept = 1'b1;
         end
         else
         begin
            irqAccept = intEnable && (irqPriority > priorityLevel);
         end
      end
   end
endmodule

// [rtl/crs_register_set.sv]
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
module crs_register_set
   import crs_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   input  wire logic [5:0]  regAddr,
   input  wire logic [31:0] regWrData,
   input  wire logic        regWrStrobe,
   input  wire logic        regRdStrobe,
   output logic      [31:0] regRdData,
   input  wire logic        execWrite,
   input  wire logic [2:0]  execSel,
   input  wire logic [15:0] execData,
   input  wire logic        aluUpdate,
   input  wire logic [15:0] aluResult,
   input  wire logic        aluByteOp,
   input  wire logic        aluCarry,
   input  wire logic        aluOverflow,
   input  wire logic        pcLoad,
   input  wire logic [19:0] pcNext,
   input  wire logic        spLoad,
   input  wire logic [15:0] spNext,
   input  wire logic        irqRequest,
   input  wire logic        irqNonMaskable,
   input  wire logic [2:0]  irqPriority,
   input  wire logic        irqAck,
   input  wire logic        swIntExec,
   input  wire logic [5:0]  swIntNum,
   output logic             irqAccept,
   output logic      [15:0] processorFlags,
   output logic      [19:0] pcOut,
   output logic      [19:0] intbOut,
   output logic      [15:0] activeSp,
   output logic      [15:0] frameBaseOut,
   output logic      [15:0] staticBaseOut,
   output logic      [31:0] addressPairOut,
   output logic      [31:0] dataPairLowOut,
   output logic      [31:0] dataPairHighOut,
   output logic             bankSelect
);
   logic [BANK_REGS-1:0] loEn [NUM_BANKS];
   logic [BANK_REGS-1:0] hiEn [NUM_BANKS];
   logic [15:0]          bankWrVal [BANK_REGS];
   logic [15:0]          bankQ [NUM_BANKS][BANK_REGS];
   logic [15:0]          curQ [BANK_REGS];
   logic [15:0]          flags_reg;
   logic [15:0]          flags_next;
   logic [19:0]          pc_reg;
   logic [19:0]          interrupt_table_base_reg;
   logic [15:0]          usp_reg;
   logic [15:0]          isp_reg;
   logic [15:0]          sb_reg;
   logic [31:0]          rdData_reg;
   logic [31:0]          readMux;
   logic                 aluZero;
   logic                 aluSign;
   logic                 swiStack;

   assign bankSelect = flags_reg[FLG_BANK];

   // Both banks hold the data, address and frame base registers.
   for (genvar b = 0; b < NUM_BANKS; b++)
   begin : g_bank
      for (genvar k = 0; k < BANK_REGS; k++)
      begin : g_reg
         crs_word_reg u_reg (
            .clk  (ref_clk),
            .rst  (sys_rst),
            .wrLo (loEn[b][k]),
            .wrHi (hiEn[b][k]),
            .dIn  (bankWrVal[k]),
            .q    (bankQ[b][k])
         );
      end
   end

   always_comb
   begin
      for (int k = 0; k < BANK_REGS; k++)
      begin
         curQ[k] = bankQ[bankSelect][k];
      end
   end

   always_comb
   begin
      for (int k = 0; k < BANK_REGS; k++)
      begin
         bankWrVal[k] = regWrData[15:0];
      end
      for (int b = 0; b < NUM_BANKS; b++)
      begin
         loEn[b] = '0;
         hiEn[b] = '0;
      end
      if (regWrStrobe)
      begin
         if (regAddr < ADDR_SBASE)
         begin
            loEn[bankSelect][regAddr[2:0]] = 1'b1;
            hiEn[bankSelect][regAddr[2:0]] = 1'b1;
         end
         case (regAddr)
            ADDR_DATA0_LO:
            begin
               loEn[bankSelect][BR_DATA0] = 1'b1;
               bankWrVal[BR_DATA0] = {regWrData[7:0], regWrData[7:0]};
            end
            ADDR_DATA0_HI:
            begin
               hiEn[bankSelect][BR_DATA0] = 1'b1;
               bankWrVal[BR_DATA0] = {regWrData[7:0], regWrData[7:0]};
            end
            ADDR_DATA1_LO:
            begin
               loEn[bankSelect][BR_DATA1] = 1'b1;
               bankWrVal[BR_DATA1] = {regWrData[7:0], regWrData[7:0]};
            end
            ADDR_DATA1_HI:
            begin
               hiEn[bankSelect][BR_DATA1] = 1'b1;
               bankWrVal[BR_DATA1] = {regWrData[7:0], regWrData[7:0]};
            end
            ADDR_PAIR_LOW:
            begin
               loEn[bankSelect][BR_DATA0] = 1'b1;
               hiEn[bankSelect][BR_DATA0] = 1'b1;
               loEn[bankSelect][BR_DATA2] = 1'b1;
               hiEn[bankSelect][BR_DATA2] = 1'b1;
               bankWrVal[BR_DATA2] = regWrData[31:16];
            end
            ADDR_PAIR_HIGH:
            begin
               loEn[bankSelect][BR_DATA1] = 1'b1;
               hiEn[bankSelect][BR_DATA1] = 1'b1;
               loEn[bankSelect][BR_DATA3] = 1'b1;
               hiEn[bankSelect][BR_DATA3] = 1'b1;
               bankWrVal[BR_DATA3] = regWrData[31:16];
            end
            ADDR_ADDR_PAIR:
            begin
               loEn[bankSelect][BR_ADDR0] = 1'b1;
               hiEn[bankSelect][BR_ADDR0] = 1'b1;
               loEn[bankSelect][BR_ADDR1] = 1'b1;
               hiEn[bankSelect][BR_ADDR1] = 1'b1;
               bankWrVal[BR_ADDR1] = regWrData[31:16];
            end
            default:
            begin
            end
         endcase
      end
      // The execution unit owns the register it writes in the same cycle.
      if (execWrite && (execSel <= BR_FBASE))
      begin
         loEn[bankSelect][execSel] = 1'b1;
         hiEn[bankSelect][execSel] = 1'b1;
         bankWrVal[execSel] = execData;
      end
   end

   assign aluZero  = aluByteOp ? (aluResult[7:0] == 8'h00) : (aluResult == 16'h0000);
   assign aluSign  = aluByteOp ? aluResult[7] : aluResult[15];
   assign swiStack = swIntExec && (swIntNum < SWI_STACK_LIMIT);

   // Software writes first, ALU results next, interrupt entry last.
   always_comb
   begin
      flags_next = flags_reg;
      if (regWrStrobe && (regAddr == ADDR_FLAGS))
      begin
         flags_next = regWrData[15:0] & FLG_IMPL_MASK;
      end
      if (aluUpdate)
      begin
         flags_next[FLG_CARRY] = aluCarry;
         flags_next[FLG_ZERO]  = aluZero;
         flags_next[FLG_SIGN]  = aluSign;
         flags_next[FLG_OVFL]  = aluOverflow;
      end
      if (irqAck || swIntExec)
      begin
         flags_next[FLG_IEN] = 1'b0;
      end
      if (irqAck || swiStack)
      begin
         flags_next[FLG_STACK] = 1'b0;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         flags_reg <= FLAGS_RESET;
      end
      else
      begin
         flags_reg <= flags_next;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         pc_reg <= PC_RESET;
      end
      else if (pcLoad)
      begin
         pc_reg <= pcNext;
      end
      else if (regWrStrobe && (regAddr == ADDR_PC))
      begin
         pc_reg <= regWrData[19:0];
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         interrupt_table_base_reg <= INTERRUPT_TABLE_BASE_RESET;
         sb_reg   <= WORD_RESET;
      end
      else if (regWrStrobe)
      begin
         if (regAddr == ADDR_INTERRUPT_TABLE_BASE)
         begin
            interrupt_table_base_reg <= regWrData[19:0];
         end
         if (regAddr == ADDR_SBASE)
         begin
            sb_reg <= regWrData[15:0];
         end
      end
   end

   // Stack moves from execution land on the pointer that stack select names.
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         usp_reg <= WORD_RESET;
         isp_reg <= WORD_RESET;
      end
      else
      begin
         if (spLoad && flags_reg[FLG_STACK])
         begin
            usp_reg <= spNext;
         end
         else if (regWrStrobe && ((regAddr == ADDR_USP) ||
                  ((regAddr == ADDR_ACTIVE_SP) && flags_reg[FLG_STACK])))
         begin
            usp_reg <= regWrData[15:0];
         end
         if (spLoad && !flags_reg[FLG_STACK])
         begin
            isp_reg <= spNext;
         end
         else if (regWrStrobe && ((regAddr == ADDR_ISP) ||
                  ((regAddr == ADDR_ACTIVE_SP) && !flags_reg[FLG_STACK])))
         begin
            isp_reg <= regWrData[15:0];
         end
      end
   end

   always_comb
   begin
      readMux = 32'h00000000;
      if (regAddr < ADDR_SBASE)
      begin
         readMux = {16'h0000, curQ[regAddr[2:0]]};
      end
      else
      begin
         case (regAddr)
            ADDR_SBASE:     readMux = {16'h0000, sb_reg};
            ADDR_USP:       readMux = {16'h0000, usp_reg};
            ADDR_ISP:       readMux = {16'h0000, isp_reg};
            ADDR_INTERRUPT_TABLE_BASE:      readMux = {12'h000, interrupt_table_base_reg};
            ADDR_PC:        readMux = {12'h000, pc_reg};
            ADDR_FLAGS:     readMux = {16'h0000, flags_reg};
            ADDR_DATA0_LO:  readMux = {24'h000000, curQ[BR_DATA0][7:0]};
            ADDR_DATA0_HI:  readMux = {24'h000000, curQ[BR_DATA0][15:8]};
            ADDR_DATA1_LO:  readMux = {24'h000000, curQ[BR_DATA1][7:0]};
            ADDR_DATA1_HI:  readMux = {24'h000000, curQ[BR_DATA1][15:8]};
            ADDR_ACTIVE_SP: readMux = {16'h0000, activeSp};
            ADDR_PAIR_LOW:  readMux = dataPairLowOut;
            ADDR_PAIR_HIGH: readMux = dataPairHighOut;
            ADDR_ADDR_PAIR: readMux = addressPairOut;
            default:        readMux = 32'h00000000;
         endcase
      end
   end

   // Read data stands for exactly the cycle after the strobe.
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         rdData_reg <= 32'h00000000;
      end
      else
      begin
         rdData_reg <= regRdStrobe ? readMux : 32'h00000000;
      end
   end

   crs_irq_gate u_irq_gate (
      .irqRequest     (irqRequest),
      .irqNonMaskable (irqNonMaskable),
      .irqPriority    (irqPriority),
      .priorityLevel  (flags_reg[FLG_IPL_HI:FLG_IPL_LO]),
      .intEnable      (flags_reg[FLG_IEN]),
      .irqAccept      (irqAccept)
   );

   assign regRdData       = rdData_reg;
   assign processorFlags  = flags_reg;
   assign pcOut           = pc_reg;
   assign intbOut         = interrupt_table_base_reg;
   assign staticBaseOut   = sb_reg;
   assign frameBaseOut    = curQ[BR_FBASE];
   assign activeSp        = flags_reg[FLG_STACK] ? usp_reg : isp_reg;
   assign dataPairLowOut  = {curQ[BR_DATA2], curQ[BR_DATA0]};
   assign dataPairHighOut = {curQ[BR_DATA3], curQ[BR_DATA1]};
   assign addressPairOut  = {curQ[BR_ADDR1], curQ[BR_ADDR0]};

   default clocking cb_main @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   a_read_idle: assert property (!regRdStrobe |=> regRdData == 32'h00000000)
      else $error("read data not zero outside read answer");
   a_pc_read: assert property (regRdStrobe && (regAddr == ADDR_PC)
                               |=> regRdData[19:0] == $past(pc_reg))
      else $error("program counter read mismatch");
   a_pc_load: assert property (pcLoad |=> pcOut == $past(pcNext))
      else $error("program counter not loaded");
   a_carry_flag: assert property (aluUpdate |=> flags_reg[FLG_CARRY] == $past(aluCarry))
      else $error("carry flag wrong");
   a_zero_flag: assert property (aluUpdate |=> flags_reg[FLG_ZERO] == $past(aluZero))
      else $error("zero flag wrong");
   a_sign_flag: assert property (aluUpdate |=> flags_reg[FLG_SIGN] == $past(aluSign))
      else $error("sign flag wrong");
   a_ovfl_flag: assert property (aluUpdate |=> flags_reg[FLG_OVFL] == $past(aluOverflow))
      else $error("overflow flag wrong");
   a_irq_masked: assert property (!flags_reg[FLG_IEN] && !irqNonMaskable |-> !irqAccept)
      else $error("masked interrupt accepted");
   a_ack_clears_ie: assert property (irqAck || swIntExec |=> !processorFlags[FLG_IEN])
      else $error("interrupt enable not cleared");
   a_stack_select_clear: assert property (irqAck || swiStack |=> !flags_reg[FLG_STACK])
      else $error("stack select not cleared");
   a_irq_priority: assert property (irqAccept && !irqNonMaskable
                                    |-> irqPriority > flags_reg[FLG_IPL_HI:FLG_IPL_LO])
      else $error("interrupt accepted at or below level");
   a_isp_push: assert property (spLoad && !flags_reg[FLG_STACK]
                                |=> isp_reg == $past(spNext))
      else $error("interrupt stack pointer not loaded");
   a_reserved_zero: assert property ((processorFlags & ~FLG_IMPL_MASK) == 16'h0000)
      else $error("reserved flag bits hold state");
endmodule

// [test/crs_core_model.sv]
`timescale 1ns/1ps
// Interrupt side of the core: raises a request and acknowledges it a chosen number of
// cycles after the register set accepts it, so both prompt and slow answers occur.
module crs_core_model
   import crs_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       sys_rst,
   input  wire logic       reqStart,
   input  wire logic       reqCancel,
   input  wire logic       reqNmi,
   input  wire logic [2:0] reqPrio,
   input  wire logic [7:0] ackDelay,
   input  wire logic       irqAccept,
   output logic            irqRequest,
   output logic            irqNonMaskable,
   output logic      [2:0] irqPriority,
   output logic            irqAck
);
   logic [7:0] waitCnt;

   assign irqNonMaskable = reqNmi;
   assign irqPriority    = reqPrio;

   always_ff @(posedge ref_clk)
   begin
      irqAck <= 1'b0;
      if (sys_rst || reqCancel)
      begin
         irqRequest <= 1'b0;
         waitCnt    <= 8'h00;
      end
      else if (reqStart)
      begin
         irqRequest <= 1'b1;
         waitCnt    <= 8'h00;
      end
      else if (irqRequest && irqAccept)
      begin
         if (waitCnt == ackDelay)
         begin
            irqAck     <= 1'b1;
            irqRequest <= 1'b0;
         end
         else
            waitCnt <= waitCnt + 8'h01;
      end
   end
endmodule

// [test/crs_register_set_tb.sv]
`timescale 1ns/1ps
module crs_register_set_tb
   import crs_pkg::*;
   ;
   logic        ref_clk, sys_rst, regWrStrobe, regRdStrobe, execWrite, aluUpdate;
   logic        aluByteOp, aluCarry, aluOverflow, pcLoad, spLoad, irqRequest, irqAck;
   logic        irqNonMaskable, swIntExec, irqAccept, bankSelect, reqStart, reqCancel;
   logic        reqNmi, b;
   logic [2:0]  execSel, irqPriority, reqPrio;
   logic [3:0]  aluFlags;
   logic [5:0]  regAddr, swIntNum;
   logic [7:0]  ackDelay;
   logic [15:0] execData, aluResult, spNext, processorFlags, activeSp, r;
   logic [15:0] frameBaseOut, staticBaseOut, seed;
   logic [19:0] pcNext, pcOut, intbOut;
   logic [31:0] regWrData, regRdData, addressPairOut, dataPairLowOut, dataPairHighOut;
   logic [31:0] v, f;
   logic [31:0] mem     [0:11];
   logic [15:0] corner  [0:3] = '{16'h0000, 16'h8000, 16'hff00, 16'h0080};
   logic [5:0]  swNums  [0:3] = '{6'h1f, 6'h20, 6'h00, 6'h3f};
   int          n_fail, comparisons, i, k;

   assign aluFlags = {processorFlags[FLG_OVFL], processorFlags[FLG_SIGN],
                      processorFlags[FLG_ZERO], processorFlags[FLG_CARRY]};

   crs_register_set u_crs_register_set (.ref_clk, .sys_rst, .regAddr, .regWrData,
      .regWrStrobe, .regRdStrobe, .regRdData, .execWrite, .execSel, .execData, .aluUpdate,
      .aluResult, .aluByteOp, .aluCarry, .aluOverflow, .pcLoad, .pcNext, .spLoad, .spNext,
      .irqRequest, .irqNonMaskable, .irqPriority, .irqAck, .swIntExec, .swIntNum,
      .irqAccept, .processorFlags, .pcOut, .intbOut, .activeSp, .frameBaseOut,
      .staticBaseOut, .addressPairOut, .dataPairLowOut, .dataPairHighOut, .bankSelect);

   crs_core_model u_crs_core_model (.ref_clk, .sys_rst, .reqStart, .reqCancel, .reqNmi,
      .reqPrio, .ackDelay, .irqAccept, .irqRequest, .irqNonMaskable, .irqPriority, .irqAck);

   initial
   begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   function automatic logic [15:0] nxt();
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      return seed;
   endfunction

   // Expected {overflow, sign, zero, carry}; byte operations judge the low byte.
   function automatic logic [3:0] alu_exp(input logic [15:0] rs, input logic bo,
                                          input logic c, input logic o);
      return {o, bo ? rs[7] : rs[15], bo ? (rs[7:0] == 8'h00) : (rs == 16'h0000), c};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic close_out();
      $display("Mismatches %0d, comparisons %0d", n_fail, comparisons);
      if (n_fail == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      regAddr <= a;
      regWrData <= d;
      regWrStrobe <= 1'b1;
      @(posedge ref_clk);
      regWrStrobe <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic rd(input logic [5:0] a, input logic [31:0] exp);
      regAddr <= a;
      regRdStrobe <= 1'b1;
      @(posedge ref_clk);
      regRdStrobe <= 1'b0;
      #1 chk(regRdData, exp);
      @(posedge ref_clk);
   endtask

   // Ends every one-cycle pulse of the execution side and lets its result settle.
   task automatic step();
      @(posedge ref_clk);
      {execWrite, aluUpdate, pcLoad, spLoad, swIntExec, reqStart, reqCancel} <= '0;
      @(posedge ref_clk);
      #1;
   endtask

   initial
   begin
      {regWrStrobe, regRdStrobe, execWrite, aluUpdate, aluByteOp, aluCarry} = '0;
      {aluOverflow, pcLoad, spLoad, swIntExec, reqStart, reqCancel, reqNmi} = '0;
      {regAddr, swIntNum, execSel, reqPrio, ackDelay, regWrData} = '0;
      {execData, aluResult, spNext, pcNext} = '0;
      n_fail = 0;
      comparisons = 0;
      seed = 16'h004b;
      sys_rst = 1'b1;
      repeat (8) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      for (i = 0; i <= 20; i++)
         rd(i[5:0], 32'h0);
      rd(6'h3f, 32'h0);
      for (i = 0; i < 12; i++)
      begin
         v = {nxt(), nxt()};
         mem[i] = v & ((i > 9) ? 32'h000fffff : 32'h0000ffff);
         wr(i[5:0], v);
         rd(i[5:0], mem[i]);
      end
      #1 chk({12'h0, pcOut}, mem[11]);
      chk({12'h0, intbOut}, mem[10]);
      chk({16'h0, frameBaseOut}, mem[6]);
      chk({16'h0, staticBaseOut}, mem[7]);
      chk(dataPairHighOut, {mem[3][15:0], mem[1][15:0]});
      chk(addressPairOut, {mem[5][15:0], mem[4][15:0]});
      chk({16'h0, activeSp}, mem[9]);
      wr(ADDR_FLAGS, 32'h1 << FLG_BANK);
      #1 chk({31'h0, bankSelect}, 32'h1);
      rd(6'h00, 32'h0);
      v = {16'h0, nxt()};
      wr(6'h00, v);
      rd(6'h00, v);
      wr(ADDR_FLAGS, 32'h0);
      rd(6'h00, mem[0]);
      for (k = 0; k < 2; k++)
      begin
         v = {16'h0, nxt()};
         wr(ADDR_DATA0_LO + 6'(2 * k), {24'hffffff, v[7:0]});
         wr(ADDR_DATA0_HI + 6'(2 * k), {24'h5a5a5a, v[15:8]});
         rd(k[5:0], v);
         rd(ADDR_DATA0_LO + 6'(2 * k), {24'h0, v[7:0]});
         rd(ADDR_DATA0_HI + 6'(2 * k), {24'h0, v[15:8]});
      end
      for (k = 0; k < 3; k++)
      begin
         v = {nxt(), nxt()};
         wr(ADDR_PAIR_LOW + k[5:0], v);
         if (k == 0)
            #1 chk(dataPairLowOut, v);
         rd(6'(k == 2 ? 4 : k), {16'h0, v[15:0]});
         rd(6'(k == 2 ? 5 : k + 2), {16'h0, v[31:16]});
         rd(ADDR_PAIR_LOW + k[5:0], v);
      end
      v = {16'h0, nxt()};
      spNext <= v[15:0];
      spLoad <= 1'b1;
      step();
      rd(ADDR_ISP, v);
      wr(ADDR_FLAGS, 32'h1 << FLG_STACK);
      rd(ADDR_ACTIVE_SP, mem[8]);
      v = {16'h0, nxt()};
      wr(ADDR_ACTIVE_SP, v);
      rd(ADDR_USP, v);
      for (i = 0; i < 24; i++)
      begin
         v = {nxt(), nxt()};
         r = (i < 4) ? corner[i] : v[15:0];
         b = (i < 4) ? i[1] : v[16];
         aluResult <= r;
         aluByteOp <= b;
         aluCarry <= v[17];
         aluOverflow <= v[18];
         aluUpdate <= 1'b1;
         step();
         chk({28'h0, aluFlags}, 32'(alu_exp(r, b, v[17], v[18])));
      end
      for (i = 0; i < 256; i++)
      begin
         f = (32'(i[6]) << FLG_IEN) | (32'(i[5:3]) << FLG_IPL_LO);
         wr(ADDR_FLAGS, f);
         rd(ADDR_FLAGS, f);
         reqPrio <= i[2:0];
         reqNmi <= i[7];
         ackDelay <= 8'hff;
         reqStart <= 1'b1;
         step();
         chk({31'h0, irqAccept}, {31'h0, i[7] | (i[6] & (i[2:0] > i[5:3]))});
         reqCancel <= 1'b1;
         step();
      end
      for (k = 0; k < 2; k++)
      begin
         f = (32'h1 << FLG_STACK) | (32'h2 << FLG_IPL_LO) | (32'h1 << FLG_BANK);
         f = f | (32'(k == 0) << FLG_IEN);
         wr(ADDR_FLAGS, f);
         reqPrio <= 3'h5;
         reqNmi <= (k == 1);
         ackDelay <= (k == 0) ? 8'h03 : 8'h00;
         reqStart <= 1'b1;
         step();
         for (i = 0; i < 20 && irqAck !== 1'b1; i++)
            @(posedge ref_clk) #1;
         chk({31'h0, irqAck}, 32'h1);
         @(posedge ref_clk);
         #1 chk({16'h0, processorFlags & FLG_IMPL_MASK}, f & 32'hffffff3f);
      end
      for (k = 0; k < 4; k++)
      begin
         wr(ADDR_FLAGS, (32'h1 << FLG_STACK) | (32'h1 << FLG_IEN));
         swIntNum <= swNums[k];
         swIntExec <= 1'b1;
         step();
         chk({16'h0, processorFlags & FLG_IMPL_MASK}, swNums[k][5] ? 32'h80 : 32'h0);
      end
      for (k = 0; k < 8; k++)
      begin
         f = v;
         v = {nxt(), nxt()};
         execSel <= k[2:0];
         execData <= v[15:0];
         execWrite <= 1'b1;
         pcNext <= v[31:12];
         pcLoad <= 1'b1;
         step();
         chk({12'h0, pcOut}, {12'h0, v[31:12]});
         rd(6'(k < 7 ? k : 6), {16'h0, (k < 7) ? v[15:0] : f[15:0]});
      end
      sys_rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      rd(ADDR_PC, 32'h0);
      rd(ADDR_FLAGS, 32'h0);
      close_out();
   end
endmodule
